/* design/ucs_defines.vh */
// Register map, field positions, reset values and timing counts of the serial port control block.
`ifndef UCS_DEFINES_VH
`define UCS_DEFINES_VH
`define UCS_AW 6
`define UCS_IDX_BUF 6'h00
`define UCS_IDX_IER 6'h01
`define UCS_IDX_IIR 6'h02
`define UCS_IDX_LCR 6'h03
`define UCS_IDX_LSR 6'h05
`define UCS_IDX_SCR 6'h07
`define UCS_IDX_SBUF_LO 6'h0C
`define UCS_IDX_SBUF_HI 6'h1B
`define UCS_IDX_FCRR 6'h1F
`define UCS_IDX_SFE 6'h26
`define UCS_IDX_SRT 6'h27
`define UCS_IDX_STET 6'h28
`define UCS_IER_RDA 0
`define UCS_IER_TRANSMIT_HOLDING_EMPTY 1
`define UCS_IER_RLS 2
`define UCS_IER_PTIME 7
`define UCS_FCR_EN 0
`define UCS_FCR_RXCLR 1
`define UCS_FCR_TXCLR 2
`define UCS_FCR_KEEP 8'hF9
`define UCS_LSR_TRANSMIT_HOLDING_EMPTY 5
`define UCS_IIR_NONE 4'h1
`define UCS_IIR_RLS 4'h6
`define UCS_IIR_RDA 4'h4
`define UCS_IIR_TMO 4'hC
`define UCS_IIR_TRANSMIT_HOLDING_EMPTY 4'h2
`define UCS_RST_IER 8'h00
`define UCS_RST_FCR 8'h00
`define UCS_RST_LCR 8'h00
`define UCS_RST_SCR 8'h00
`define UCS_CHAR_TIMES 4
`define UCS_SETTLE_MAX 8
`define UCS_SYNC_STAGES 2
`endif

/* design/ucs_sync.v */
// Two-flop synchroniser for a bundle of signals crossing into the sampling logic.
`timescale 1ns/1ps
`default_nettype none
module ucs_sync #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // The first stage feeds only the second stage.
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= din[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign dout = sync_q;
endmodule // ucs_sync
`default_nettype wire

/* design/ucs_chartmo.v */
// Character timeout detector for the receive FIFO.
`timescale 1ns/1ps
`default_nettype none
module ucs_chartmo #(
  parameter CW = 16,
  parameter [CW-1:0] LIMIT = 16'd640
) (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire nonempty,
  input wire activity,
  output reg tmo_q
);
  reg [CW-1:0] cnt_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {CW{1'b0}};
      tmo_q <= 1'b0;
    end else if (!enable || !nonempty || activity) begin
      // Any push or pop restarts the window and clears a reported timeout.
      cnt_q <= {CW{1'b0}};
      tmo_q <= 1'b0;
    end else if (cnt_q >= LIMIT - 1'b1) begin
      tmo_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // ucs_chartmo
`default_nettype wire

/* design/ucs_top.v */
// Serial port control: Avalon register slave, interrupt identity, threshold mode and shadow aliases.
`timescale 1ns/1ps
`default_nettype none
`include "ucs_defines.vh"
module ucs_top #(
  parameter FIFO_DEPTH = 16,
  parameter LVL_W = 5,
  parameter CHAR_CLKS = 160
) (
  input wire clk,
  input wire rst,
  input wire [`UCS_AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq,
  input wire [7:0] ser_rx_data,
  input wire [LVL_W-1:0] ser_rx_level,
  input wire [LVL_W-1:0] ser_tx_level,
  input wire ser_rx_push,
  input wire ser_tx_pop,
  input wire [3:0] ser_err,
  input wire ser_tx_idle,
  output reg tx_wr,
  output reg [7:0] tx_data,
  output reg rx_rd,
  output reg rx_clr,
  output reg tx_clr,
  output wire [7:0] cfg_lcr,
  output wire cfg_fifo_en,
  output reg ser_rst
);
  // Level constants are worked out as integers first and then cut to their width on purpose.
  localparam integer QTR_I = FIFO_DEPTH / 4;
  localparam integer HALF_I = FIFO_DEPTH / 2;
  localparam integer NEAR_I = FIFO_DEPTH - 2;
  localparam integer FULL_I = FIFO_DEPTH;
  localparam integer TMO_I = `UCS_CHAR_TIMES * CHAR_CLKS;
  localparam integer SETTLE_I = `UCS_SETTLE_MAX - `UCS_SYNC_STAGES - 1;
  localparam integer ONE_I = 1;
  localparam integer TWO_I = 2;

  localparam [LVL_W-1:0] LV_ZERO = {LVL_W{1'b0}};
  localparam [LVL_W-1:0] LV_ONE = ONE_I[LVL_W-1:0];
  localparam [LVL_W-1:0] LV_TWO = TWO_I[LVL_W-1:0];
  localparam [LVL_W-1:0] LV_QTR = QTR_I[LVL_W-1:0];
  localparam [LVL_W-1:0] LV_HALF = HALF_I[LVL_W-1:0];
  localparam [LVL_W-1:0] LV_NEAR = NEAR_I[LVL_W-1:0];
  localparam [LVL_W-1:0] LV_FULL = FULL_I[LVL_W-1:0];
  localparam [15:0] TMO_LIMIT = TMO_I[15:0];
  localparam [3:0] SETTLE_CNT = SETTLE_I[3:0];
  localparam integer ST_W = 8 + 2 * LVL_W + 7;

  reg [7:0] ier_q;
  reg [7:0] fcr_q;
  reg [7:0] lcr_q;
  reg [7:0] scr_q;
  reg [3:0] err_q;
  reg transmit_holding_empty_pend_q;
  reg transmit_holding_empty_prev_q;
  reg [8:0] cfg_prev_q;
  reg [3:0] settle_q;
  reg [31:0] rd_mux;
  reg [3:0] iir_id;
  reg [LVL_W-1:0] rx_trig;
  reg [LVL_W-1:0] tx_thr;

  wire [7:0] s_rx_data;
  wire [LVL_W-1:0] s_rx_level;
  wire [LVL_W-1:0] s_tx_level;
  wire s_rx_push;
  wire s_tx_pop;
  wire [3:0] s_err;
  wire s_tx_idle;
  wire [8:0] cfg_s;
  wire tmo_act;

  // Status from the serial engine and configuration toward it both cross through synchronisers.
  ucs_sync #(.WIDTH(ST_W)) u_st_sync (
    .clk(clk),
    .rst(rst),
    .din({ser_rx_data, ser_rx_level, ser_tx_level, ser_rx_push, ser_tx_pop, ser_err, ser_tx_idle}),
    .dout({s_rx_data, s_rx_level, s_tx_level, s_rx_push, s_tx_pop, s_err, s_tx_idle})
  );

  ucs_sync #(.WIDTH(9)) u_cfg_sync (
    .clk(clk),
    .rst(rst),
    .din({lcr_q, fcr_q[`UCS_FCR_EN]}),
    .dout(cfg_s)
  );

  assign cfg_lcr = cfg_s[8:1];
  assign cfg_fifo_en = cfg_s[0];

  // Bus handshake: a request is answered one cycle later and takes effect at the edge that sees waitrequest low.
  wire req = avs_read | avs_write;
  wire acc = req & ~avs_waitrequest;
  wire acc_wr = acc & avs_write & avs_byteenable[0];
  wire acc_rd = acc & avs_read;
  wire [7:0] wd = avs_writedata[7:0];
  wire in_sbuf = (avs_address >= `UCS_IDX_SBUF_LO) && (avs_address <= `UCS_IDX_SBUF_HI);
  wire is_buf = (avs_address == `UCS_IDX_BUF) | in_sbuf;

  wire fifo_on = fcr_q[`UCS_FCR_EN];
  wire ptime = ier_q[`UCS_IER_PTIME] & fifo_on;
  wire tx_empty = (s_tx_level == LV_ZERO);
  wire tx_full = (s_tx_level >= LV_FULL);
  wire rx_nonempty = (s_rx_level != LV_ZERO);

  // Receive trigger levels: one character, a quarter, a half, or two short of full.
  always @* begin
    case (fcr_q[7:6])
      2'b00: rx_trig = LV_ONE;
      2'b01: rx_trig = LV_QTR;
      2'b10: rx_trig = LV_HALF;
      default: rx_trig = LV_NEAR;
    endcase
  end

  // Transmit thresholds: empty, two entries, a quarter or a half of the FIFO.
  always @* begin
    case (fcr_q[5:4])
      2'b00: tx_thr = LV_ZERO;
      2'b01: tx_thr = LV_TWO;
      2'b10: tx_thr = LV_QTR;
      default: tx_thr = LV_HALF;
    endcase
  end

  // In threshold mode the condition follows the fill level, otherwise it means empty.
  wire transmit_holding_empty_cond = ptime ? (s_tx_level <= tx_thr) : tx_empty;
  wire rls_act = |err_q;
  wire rda_act = fifo_on ? (s_rx_level >= rx_trig) : rx_nonempty;

  // The character timeout exists only while the FIFOs are on.
  ucs_chartmo #(.CW(16), .LIMIT(TMO_LIMIT)) u_tmo (
    .clk(clk),
    .rst(rst),
    .enable(fifo_on),
    .nonempty(rx_nonempty),
    .activity(s_rx_push | rx_rd),
    .tmo_q(tmo_act)
  );

  // Fixed priority: line status, receive data, timeout, transmit empty.
  always @* begin
    if (ier_q[`UCS_IER_RLS] & rls_act) begin
      iir_id = `UCS_IIR_RLS;
    end else if (ier_q[`UCS_IER_RDA] & rda_act) begin
      iir_id = `UCS_IIR_RDA;
    end else if (ier_q[`UCS_IER_RDA] & tmo_act) begin
      iir_id = `UCS_IIR_TMO;
    end else if (ier_q[`UCS_IER_TRANSMIT_HOLDING_EMPTY] & transmit_holding_empty_pend_q) begin
      iir_id = `UCS_IIR_TRANSMIT_HOLDING_EMPTY;
    end else begin
      iir_id = `UCS_IIR_NONE;
    end
  end

  // Line status bit 5 reports a full FIFO instead of an empty one in threshold mode.
  wire [7:0] line_status_register = {fifo_on & (|err_q[3:1]), tx_empty & s_tx_idle,
                    ptime ? tx_full : tx_empty,
                    err_q, rx_nonempty};

  // Read data are prepared combinationally and registered in the cycle that answers the request.
  always @* begin
    rd_mux = 32'h00000000;
    if (is_buf) begin
      rd_mux[7:0] = s_rx_data;
    end else begin
      case (avs_address)
        `UCS_IDX_IER: rd_mux[7:0] = ier_q;
        `UCS_IDX_IIR: rd_mux[7:0] = {fifo_on, fifo_on, 2'b00, iir_id};
        `UCS_IDX_LCR: rd_mux[7:0] = lcr_q;
        `UCS_IDX_LSR: rd_mux[7:0] = line_status_register;
        `UCS_IDX_SCR: rd_mux[7:0] = scr_q;
        `UCS_IDX_FCRR: rd_mux[7:0] = fcr_q;
        `UCS_IDX_SFE: rd_mux[0] = fcr_q[`UCS_FCR_EN];
        `UCS_IDX_SRT: rd_mux[1:0] = fcr_q[7:6];
        `UCS_IDX_STET: rd_mux[1:0] = fcr_q[5:4];
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (req & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Write and read strobes, each valid only at the edge that accepts the request.
  wire wr_fcr = acc_wr & (avs_address == `UCS_IDX_IIR);
  wire wr_sfe = acc_wr & (avs_address == `UCS_IDX_SFE);
  wire wr_ier = acc_wr & (avs_address == `UCS_IDX_IER);
  wire wr_lcr = acc_wr & (avs_address == `UCS_IDX_LCR);
  wire wr_scr = acc_wr & (avs_address == `UCS_IDX_SCR);
  wire wr_srt = acc_wr & (avs_address == `UCS_IDX_SRT);
  wire wr_stet = acc_wr & (avs_address == `UCS_IDX_STET);
  wire wr_buf = acc_wr & is_buf;
  wire rd_buf = acc_rd & is_buf;
  wire [7:0] fcr_new = wd & `UCS_FCR_KEEP;
  wire en_flip = (wr_fcr & (wd[`UCS_FCR_EN] != fifo_on)) | (wr_sfe & (wd[0] != fifo_on));

  // Each shadow FIFO index (SFE, SRT, STET) reaches its own FIFO control bits and leaves the others alone.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ier_q <= `UCS_RST_IER;
      fcr_q <= `UCS_RST_FCR;
      lcr_q <= `UCS_RST_LCR;
      scr_q <= `UCS_RST_SCR;
      tx_wr <= 1'b0;
      tx_data <= 8'h00;
      rx_rd <= 1'b0;
      rx_clr <= 1'b0;
      tx_clr <= 1'b0;
    end else begin
      tx_wr <= wr_buf;
      rx_rd <= rd_buf;
      // Changing the FIFO enable also empties both FIFOs.
      rx_clr <= (wr_fcr & wd[`UCS_FCR_RXCLR]) | en_flip;
      tx_clr <= (wr_fcr & wd[`UCS_FCR_TXCLR]) | en_flip;
      if (wr_buf) begin
        tx_data <= wd;
      end
      if (wr_ier) begin
        ier_q <= wd & 8'h87;
      end
      if (wr_fcr) begin
        fcr_q <= fcr_new;
      end
      if (wr_sfe) begin
        fcr_q[`UCS_FCR_EN] <= wd[0];
      end
      if (wr_srt) begin
        fcr_q[7:6] <= wd[1:0];
      end
      if (wr_stet) begin
        fcr_q[5:4] <= wd[1:0];
      end
      if (wr_lcr) begin
        lcr_q <= wd;
      end
      if (wr_scr) begin
        scr_q <= wd;
      end
    end
  end

  // Error flags: a new error in the cycle of the status read survives it.
  wire lsr_rd = acc_rd & (avs_address == `UCS_IDX_LSR);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q <= 4'h0;
    end else begin
      err_q <= (lsr_rd ? 4'h0 : err_q) | s_err;
    end
  end

  // Transmit empty source: cleared by reading it in the identity register, by a holding write
  // outside threshold mode, or by the condition dropping; a fresh condition wins over any clear.
  wire iir_transmit_holding_empty_rd = acc_rd & (avs_address == `UCS_IDX_IIR) & (avs_readdata[3:0] == `UCS_IIR_TRANSMIT_HOLDING_EMPTY);
  wire transmit_holding_empty_set = (transmit_holding_empty_cond & ~transmit_holding_empty_prev_q) | (ptime & transmit_holding_empty_cond & s_tx_pop);
  wire transmit_holding_empty_clr = iir_transmit_holding_empty_rd | (~ptime & wr_buf) | ~transmit_holding_empty_cond;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      transmit_holding_empty_prev_q <= 1'b0;
      transmit_holding_empty_pend_q <= 1'b0;
    end else begin
      transmit_holding_empty_prev_q <= transmit_holding_empty_cond;
      if (transmit_holding_empty_set) begin
        transmit_holding_empty_pend_q <= 1'b1;
      end else if (transmit_holding_empty_clr) begin
        transmit_holding_empty_pend_q <= 1'b0;
      end
    end
  end

  // The interrupt line follows the identity one cycle later, so both agree on a read.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (iir_id != `UCS_IIR_NONE);
    end
  end

  // Serial engine reset: held after any configuration change seen past the synchroniser,
  // so that the whole path stays within the settling bound.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_prev_q <= 9'h000;
      settle_q <= 4'h0;
      ser_rst <= 1'b1;
    end else begin
      cfg_prev_q <= cfg_s;
      if (cfg_s != cfg_prev_q) begin
        settle_q <= SETTLE_CNT;
        ser_rst <= 1'b1;
      end else if (settle_q != 4'h0) begin
        settle_q <= settle_q - 4'h1;
      end else begin
        ser_rst <= 1'b0;
      end
    end
  end

endmodule // ucs_top
`default_nettype wire

/* tb/ucs_props.sv */
// Port assertions for the serial port control block.
`timescale 1ns/1ps
`default_nettype none
module ucs_props (
  input wire clk,
  input wire rst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire irq,
  input wire tx_wr,
  input wire [7:0] tx_data,
  input wire rx_rd,
  input wire [7:0] cfg_lcr,
  input wire ser_rst
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = !avs_waitrequest;
  wire ra = acc && avs_read;
  wire wa = acc && avs_write && avs_byteenable[0];
  wire [5:0] a = avs_address;
  wire sb = a == 6'h00 || (a >= 6'h0C && a <= 6'h1B);
  wait_pulse_a: assert property (acc |=> avs_waitrequest)
    else $error("wait low twice");
  bus_answer_a: assert property ((avs_read || avs_write) && !acc |=> acc)
    else $error("no answer");
  id_code_a: assert property (ra && a == 6'h02 |-> avs_readdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2})
    else $error("bad identity");
  irq_id_a: assert property (ra && a == 6'h02 |-> irq == (avs_readdata[3:0] != 4'h1))
    else $error("irq mismatch");
  tx_alias_a: assert property (wa && sb |=> tx_wr && tx_data == $past(avs_writedata[7:0]))
    else $error("no push");
  rx_alias_a: assert property (ra && sb |-> ##[0:2] rx_rd)
    else $error("no pop");
  lcr_sync_a: assert property (wa && a == 6'h03 |-> ##4 cfg_lcr == $past(avs_writedata[7:0], 4))
    else $error("lcr not passed");
  settle_max_a: assert property (wa && a == 6'h03 |-> ##[1:8] ser_rst)
    else $error("no serial reset");
  settle_len_a: assert property (ser_rst [*8] |=> !ser_rst)
    else $error("reset too long");
  cover property (ra && a == 6'h02 && avs_readdata[3:0] == 4'hC);
  cover property (wa && sb && a != 6'h00);
  cover property (ser_rst ##1 !ser_rst);
endmodule // ucs_props
bind ucs_top ucs_props P (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .tx_wr, .tx_data, .rx_rd, .cfg_lcr, .ser_rst);
`default_nettype wire

/* tb/ucs_eng.sv */
// Serial engine model: receive queue and transmit fill count.
`timescale 1ns/1ps
`default_nettype none
module ucs_eng (
  input wire clk,
  input wire rst,
  input wire tx_wr,
  input wire rx_rd,
  input wire rx_clr,
  input wire tx_clr,
  input wire inj,
  input wire [7:0] injd,
  input wire drain,
  output wire [7:0] rx_data,
  output reg [4:0] rx_level,
  output reg [4:0] tx_level,
  output reg rx_push,
  output reg tx_pop,
  output wire tx_idle
);
  reg [7:0] fifo [$];
  reg [2:0] dv;
  wire pop = drain && tx_level != 5'h00 && dv == 3'h7;
  wire rd = rx_rd && rx_level != 5'h00;
  // An empty queue shows a pattern that changes every cycle.
  assign rx_data = rx_level != 5'h00 ? fifo[0] : {dv, ~dv, 2'h2};
  assign tx_idle = tx_level == 5'h00;
  // Transmit drains at most one character every eight cycles, keeping the engine slower than the bus.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_level <= 5'h00;
      tx_level <= 5'h00;
      rx_push <= 1'b0;
      tx_pop <= 1'b0;
      dv <= 3'h0;
      fifo.delete();
    end else begin
      dv <= dv + 3'h1;
      rx_push <= inj;
      tx_pop <= pop;
      tx_level <= tx_clr ? 5'h00 : tx_level + {4'h0, tx_wr} - {4'h0, pop};
      if (rx_clr) begin
        fifo.delete();
        rx_level <= 5'h00;
      end else begin
        if (rd) void'(fifo.pop_front());
        if (inj) fifo.push_back(injd);
        rx_level <= rx_level + {4'h0, inj} - {4'h0, rd};
      end
    end
  end
endmodule // ucs_eng
`default_nettype wire

/* tb/ucs_top_tb.sv */
// Self-checking bench of the serial port control block.
`timescale 1ns/1ps
`default_nettype none
module ucs_top_tb;
  localparam D = 16;
  reg clk = 0, rst = 1, rd = 0, wr = 0, inj = 0, drain = 1;
  reg [5:0] adr = 6'h00;
  reg [31:0] wd = 0, v, q;
  reg [3:0] be = 4'hF, err = 4'h0, k;
  reg [7:0] injd = 8'h00;
  wire [31:0] rdata;
  wire [7:0] txd, lcr, rxd;
  wire [4:0] rl, tl;
  wire wreq, irq, txwr, rxrd, rxclr, txclr, fen, srst, push, pop, idle;
  integer seed = 53, mismatches = 0, tests_run = 0, tc = 0, i;
  ucs_top #(.FIFO_DEPTH(D), .CHAR_CLKS(4)) DUT (.clk, .rst, .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .irq, .ser_rx_data(rxd), .ser_rx_level(rl), .ser_tx_level(tl),
    .ser_rx_push(push), .ser_tx_pop(pop), .ser_err(err), .ser_tx_idle(idle), .tx_wr(txwr),
    .tx_data(txd), .rx_rd(rxrd), .rx_clr(rxclr), .tx_clr(txclr), .cfg_lcr(lcr), .cfg_fifo_en(fen),
    .ser_rst(srst));
  ucs_eng FE (.clk, .rst, .tx_wr(txwr), .rx_rd(rxrd), .rx_clr(rxclr), .tx_clr(txclr), .inj, .injd,
    .drain, .rx_data(rxd), .rx_level(rl), .tx_level(tl), .rx_push(push), .tx_pop(pop), .tx_idle(idle));
  initial begin
    forever #2 clk = ~clk;
  end
  function [7:0] fifo_control_register(input [1:0] rt, input [1:0] tt, input en);
    fifo_control_register = {rt, tt, 3'h0, en};
  endfunction
  function [4:0] transmit_holding_register(input [1:0] s);
    transmit_holding_register = s == 0 ? 5'd0 : s == 1 ? 5'd2 : s == 2 ? D / 4 : D / 2;
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task bus(input [5:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdata;
      wr <= 0;
      rd <= 0;
    end
  endtask
  task w(input [5:0] a, input [7:0] d);
    bus(a, 1, {24'h0, d});
  endtask
  task rc(input [5:0] a, input [31:0] e);
    begin
      bus(a, 0, 0);
      chk(q, e);
    end
  endtask
  task put(input [7:0] d, input [3:0] e);
    begin
      @(posedge clk);
      inj <= 1;
      injd <= d;
      err <= e;
      @(posedge clk);
      inj <= 0;
      err <= 0;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task done(input integer t);
    $display("test %0d done", t);
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    tc <= tc + 1;
    if (tc == 20000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  initial begin
    cyc(12);
    rst <= 0;
    cyc(10);
    rc(1, 0);
    rc(3, 0);
    rc(7, 0);
    rc(6'h1F, 0);
    rc(2, 1);
    chk(irq, 0);
    done(1);
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      w(7, v[7:0]);
      rc(7, v[7:0]);
    end
    w(6'h3F, 8'h5A);
    rc(6'h3F, 0);
    be <= 4'hE;
    w(7, 8'hA5);
    be <= 4'hF;
    rc(7, v[7:0]);
    done(2);
    w(1, 8'h02);
    w(0, v[7:0]);
    cyc(20);
    chk(txd, v[7:0]);
    chk(irq, 1);
    rc(2, 2);
    rc(2, 1);
    done(3);
    w(1, 8'h01);
    put(v[7:0], 0);
    cyc(6);
    chk(irq, 1);
    rc(2, 4);
    rc(0, v[7:0]);
    v = $random(seed);
    k = $random(seed);
    put(v[7:0], 0);
    cyc(6);
    rc(6'h0C + k, v[7:0]);
    cyc(6);
    rc(2, 1);
    done(4);
    w(1, 8'h05);
    v = $random(seed);
    put(v[7:0], 4'h1);
    cyc(6);
    rc(2, 6);
    rc(5, 8'h63);
    cyc(4);
    rc(2, 4);
    rc(0, v[7:0]);
    done(5);
    w(2, fifo_control_register(2, 0, 1));
    cyc(10);
    chk(fen, 1);
    put(v[7:0], 0);
    rc(2, 8'hC1);
    cyc(30);
    rc(2, 8'hCC);
    rc(0, v[7:0]);
    cyc(6);
    rc(2, 8'hC1);
    w(6'h27, 1);
    for (i = 0; i < 4; i = i + 1) put(i[7:0], 0);
    cyc(6);
    rc(2, 8'hC4);
    rc(0, 0);
    cyc(4);
    rc(2, 8'hC1);
    w(2, fifo_control_register(1, 0, 1) | 8'h02);
    cyc(4);
    rc(5, 8'h60);
    done(6);
    w(6'h28, 2);
    w(6'h27, 0);
    rc(6'h1F, fifo_control_register(0, 2, 1));
    w(1, 8'h82);
    drain <= 0;
    for (i = 0; i < D; i = i + 1) w(0, i);
    cyc(6);
    rc(5, 8'h20);
    rc(2, 8'hC1);
    drain <= 1;
    while (tl > transmit_holding_register(2)) @(posedge clk);
    cyc(6);
    rc(2, 8'hC2);
    w(6'h26, 0);
    rc(6'h1F, fifo_control_register(0, 2, 0));
    cyc(40);
    rc(5, 8'h60);
    done(7);
    v = $random(seed);
    // A set top bit makes the write a real change of the line control value.
    v[7] = 1'b1;
    w(3, v[7:0]);
    cyc(12);
    chk(lcr, v[7:0]);
    chk(srst, 0);
    chk(fen, 0);
    rc(3, v[7:0]);
    done(8);
    end_sim;
  end
endmodule // ucs_top_tb
`default_nettype wire
